/* File: verilog/dcg_map.svh */
// constants of the debug command gate: command codes, field positions, flash addresses
`ifndef DCG_MAP_SVH
`define DCG_MAP_SVH
// ****************************************
// command codes
// ****************************************
`define DCG_CMD_REV 8'h00
`define DCG_CMD_RSV1 8'h01
`define DCG_CMD_STAT 8'h02
`define DCG_CMD_RTC 8'h03
`define DCG_CMD_WCTL 8'h04
`define DCG_CMD_RCTL 8'h05
`define DCG_CMD_WPC 8'h06
`define DCG_CMD_RPC 8'h07
`define DCG_CMD_WREG 8'h08
`define DCG_CMD_RREG 8'h09
`define DCG_CMD_WPM 8'h0a
`define DCG_CMD_RPM 8'h0b
`define DCG_CMD_WDM 8'h0c
`define DCG_CMD_RDM 8'h0d
`define DCG_CMD_CRC 8'h0e
`define DCG_CMD_RSVF 8'h0f
`define DCG_CMD_STEP 8'h10
// ****************************************
// control register layout and reset value
// ****************************************
`define DCG_CTL_MODE_BIT 7
`define DCG_CTL_RESET 8'h00
// ****************************************
// flash control register and its mass-erase command
// ****************************************
`define DCG_FLASH_CTL_ADDR 12'hff8
`define DCG_FLASH_LO_ADDR 12'hff8
`define DCG_FLASH_HI_ADDR 12'hfff
`define DCG_MASS_ERASE 8'h63
`endif

/* File: verilog/dcg_pkg.sv */
// types shared by the debug command gate modules
package dcg_pkg;
	// verdict given for a command byte
	typedef enum logic [1:0] {
		DCG_DENY = 2'b00,
		DCG_RUN = 2'b01,
		DCG_LIMIT = 2'b10
	} dcg_verdict_t;
	// gate state machine
	typedef enum logic [1:0] {
		DCG_IDLE = 2'b00,
		DCG_EXEC = 2'b01,
		DCG_WAIT = 2'b10
	} dcg_state_t;
endpackage

/* File: verilog/dcg_if.sv */
// link between the command gate and its decision table
`timescale 1ns/10ps
interface dcg_if;
	logic [7:0] code; // command byte under judgement
	logic in_debug; // debug_mode_flag
	logic protect; // readout_protect_option
	logic [1:0] verdict; // dcg_verdict_t value
	modport gate (output code, output in_debug, output protect, input verdict);
	modport table_side (input code, input in_debug, input protect, output verdict);
endinterface

/* File: verilog/dcg_table.sv */
// decision table: may a command byte run, and in which form
`timescale 1ns/10ps
`include "dcg_map.svh"
module dcg_table
	import dcg_pkg::*;
(
	// decision link
	dcg_if.table_side lk
);
	// ****************************************
	// combinational verdict
	// ****************************************
	always_comb begin
		dcg_verdict_t v;
		v = DCG_DENY;
		case (lk.code)
			// always available, never restricted
			`DCG_CMD_REV, `DCG_CMD_STAT, `DCG_CMD_RCTL: v = DCG_RUN;
			// runs everywhere, limited under protection
			`DCG_CMD_WCTL: v = lk.protect ? DCG_LIMIT : DCG_RUN;
			// debug only, protection does not matter
			`DCG_CMD_RTC, `DCG_CMD_RDM, `DCG_CMD_CRC: begin
				v = lk.in_debug ? DCG_RUN : DCG_DENY;
			end
			// debug only, refused under protection
			`DCG_CMD_WPC, `DCG_CMD_RPC, `DCG_CMD_STEP, `DCG_CMD_RREG,
			`DCG_CMD_WPM, `DCG_CMD_RPM, `DCG_CMD_WDM: begin
				v = (lk.in_debug && !lk.protect) ? DCG_RUN : DCG_DENY;
			end
			// register write, limited under protection
			`DCG_CMD_WREG: begin
				if (!lk.in_debug) begin
					v = DCG_DENY;
				end else if (lk.protect) begin
					v = DCG_LIMIT;
				end else begin
					v = DCG_RUN;
				end
			end
			// reserved and undefined codes are ignored
			default: v = DCG_DENY;
		endcase
		lk.verdict = v;
	end
endmodule // dcg_table

/* File: verilog/dcg_gate.sv */
// debug command gate: judges host command bytes and grants execution
`timescale 1ns/10ps
`include "dcg_map.svh"
// What this block does
// - normal mode allows only marked commands
// - revision and status always run
// - protected control write keeps debug bit set
// - control readback always runs
// - runtime counter read only in debug
// - write PC debug only, refused protected
// - read PC and step refused protected
// - protected register write: flash control only
// - register reads and program reads/writes refused protected
// - data write refused protected; reads allowed
module dcg_gate
	import dcg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// command byte from the serial receiver
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	// write data phase for control and register writes
	input wire logic wr_valid,
	input wire logic [11:0] wr_addr,
	input wire logic [7:0] wr_data,
	// end of the current command's data phase
	input wire logic cmd_done,
	// flash option pin
	input wire logic protect_pin,
	// granted command
	output logic grant,
	output logic refuse,
	output logic [7:0] active_cmd,
	output logic limited,
	// register write that may proceed
	output logic wr_ok,
	output logic [11:0] wr_ok_addr,
	output logic [7:0] wr_ok_data,
	// debugger control register and mode
	output logic [7:0] ctl_reg,
	output logic debug_mode_flag
);
	// ****************************************
	// pin synchroniser for the protect option
	// ****************************************
	// option pin is asynchronous to clk, so two stages come first
	logic prot_s1; // first stage, read only by second
	logic prot_s2; // synchronised option
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prot_s1 <= 1'b0;
			prot_s2 <= 1'b0;
		end else begin
			prot_s1 <= protect_pin;
			prot_s2 <= prot_s1;
		end
	end

	// ****************************************
	// decision table
	// ****************************************
	dcg_if lk ();
	assign lk.code = cmd_byte;
	assign lk.in_debug = ctl_reg[`DCG_CTL_MODE_BIT];
	assign lk.protect = prot_s2;
	dcg_table u_table (
		.lk(lk)
	);

	// is this address one of the flash control registers
	function automatic logic is_flash(input logic [11:0] a);
		is_flash = (a >= `DCG_FLASH_LO_ADDR) && (a <= `DCG_FLASH_HI_ADDR);
	endfunction

	// ****************************************
	// state and outputs
	// ****************************************
	dcg_state_t state; // gate state
	dcg_state_t next_state;
	logic next_grant;
	logic next_refuse;
	logic [7:0] next_active_cmd;
	logic next_limited;
	logic next_wr_ok;
	logic [11:0] next_wr_ok_addr;
	logic [7:0] next_wr_ok_data;
	logic [7:0] next_ctl_reg;

	// next-value computation
	always_comb begin
		next_state = state;
		next_grant = 1'b0;
		next_refuse = 1'b0;
		next_active_cmd = active_cmd;
		next_limited = limited;
		next_wr_ok = 1'b0;
		next_wr_ok_addr = wr_ok_addr;
		next_wr_ok_data = wr_ok_data;
		next_ctl_reg = ctl_reg;
		// bytes met outside the idle state are dropped without a pulse
		case (state)
			// waiting for a command byte
			DCG_IDLE: begin
				if (cmd_valid) begin
					if (lk.verdict == DCG_DENY) begin
						next_refuse = 1'b1; // no state changes
					end else begin
						next_grant = 1'b1;
						next_active_cmd = cmd_byte;
						next_limited = (lk.verdict == DCG_LIMIT);
						next_state = DCG_EXEC;
					end
				end
			end
			// command running, data phase open
			DCG_EXEC: begin
				if (wr_valid && active_cmd == `DCG_CMD_WCTL) begin
					next_ctl_reg = wr_data;
					if (limited && ctl_reg[`DCG_CTL_MODE_BIT]) begin
						next_ctl_reg[`DCG_CTL_MODE_BIT] = 1'b1;
					end
				end else if (wr_valid && active_cmd == `DCG_CMD_WREG) begin
					if (!limited) begin
						next_wr_ok = 1'b1;
					end else if (is_flash(wr_addr)) begin
						// flash control takes only mass erase
						next_wr_ok = (wr_addr != `DCG_FLASH_CTL_ADDR) ||
							(wr_data == `DCG_MASS_ERASE);
					end
					next_wr_ok_addr = wr_addr;
					next_wr_ok_data = wr_data;
				end
				if (cmd_done) begin
					next_state = DCG_WAIT;
				end
			end
			// one idle cycle between commands
			DCG_WAIT: begin
				next_state = DCG_IDLE;
				// the restriction ends together with its command
				next_limited = 1'b0;
			end
			default: next_state = DCG_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= DCG_IDLE;
			grant <= 1'b0;
			refuse <= 1'b0;
			active_cmd <= 8'h00;
			limited <= 1'b0;
			wr_ok <= 1'b0;
			wr_ok_addr <= 12'h000;
			wr_ok_data <= 8'h00;
			ctl_reg <= `DCG_CTL_RESET;
			debug_mode_flag <= 1'b0;
		end else begin
			state <= next_state;
			grant <= next_grant;
			refuse <= next_refuse;
			active_cmd <= next_active_cmd;
			limited <= next_limited;
			wr_ok <= next_wr_ok;
			wr_ok_addr <= next_wr_ok_addr;
			wr_ok_data <= next_wr_ok_data;
			ctl_reg <= next_ctl_reg;
			debug_mode_flag <= next_ctl_reg[`DCG_CTL_MODE_BIT];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	// command byte judged in this cycle
	logic take;
	assign take = (state == DCG_IDLE) && cmd_valid;

	// pc read stays closed outside debug
	a_normal_no_pc: assert property (@(posedge clk) disable iff (!rst_n)
		(take && !ctl_reg[`DCG_CTL_MODE_BIT] && cmd_byte == `DCG_CMD_RPC)
		|=> refuse && !grant)
		else $error("pc read granted outside debug");

	// a byte is never both granted and refused
	a_pulse_excl: assert property (@(posedge clk) disable iff (!rst_n)
		!(grant && refuse))
		else $error("grant and refuse together");

	// mode flag mirrors the control register bit
	a_flag_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		debug_mode_flag == ctl_reg[`DCG_CTL_MODE_BIT])
		else $error("mode flag differs from control bit");

	// revision read always runs
	a_rev_always: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_IDLE && cmd_valid && cmd_byte == `DCG_CMD_REV) |=> grant)
		else $error("revision read refused");

	// status read always runs, never restricted
	a_stat_always: assert property (@(posedge clk) disable iff (!rst_n)
		(take && cmd_byte == `DCG_CMD_STAT) |=> grant && !limited)
		else $error("status read refused");

	// control write always runs, restricted only under protection
	a_wctl_always: assert property (@(posedge clk) disable iff (!rst_n)
		(take && cmd_byte == `DCG_CMD_WCTL) |=> grant && limited == $past(prot_s2))
		else $error("control write refused");

	// protected control write keeps the debug bit
	a_mode_kept: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_EXEC && limited && ctl_reg[`DCG_CTL_MODE_BIT])
		|=> ctl_reg[`DCG_CTL_MODE_BIT])
		else $error("protected write cleared debug bit");

	// control readback always runs
	a_rctl_always: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_IDLE && cmd_valid && cmd_byte == `DCG_CMD_RCTL) |=> grant)
		else $error("control readback refused");

	// runtime counter follows the debug bit of the arrival cycle
	a_rtc_debug: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_IDLE && cmd_valid && cmd_byte == `DCG_CMD_RTC)
		|=> grant == $past(ctl_reg[`DCG_CTL_MODE_BIT]))
		else $error("runtime counter verdict wrong");

	// pc write refused under protection
	a_wpc_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_IDLE && cmd_valid && prot_s2 && cmd_byte == `DCG_CMD_WPC) |=> refuse)
		else $error("pc write under protection");

	// single step refused under protection
	a_step_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_IDLE && cmd_valid && prot_s2 && cmd_byte == `DCG_CMD_STEP) |=> refuse)
		else $error("step under protection");

	// pc read refused under protection
	a_rpc_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(take && prot_s2 && cmd_byte == `DCG_CMD_RPC) |=> refuse)
		else $error("pc read under protection");

	// register write in protected debug runs restricted
	a_wreg_limit: assert property (@(posedge clk) disable iff (!rst_n)
		(take && prot_s2 && ctl_reg[`DCG_CTL_MODE_BIT] && cmd_byte == `DCG_CMD_WREG)
		|=> grant && limited)
		else $error("protected register write not restricted");

	// restricted writes reach only the flash control range
	a_flash_only: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_ok && $past(limited)) |-> wr_ok_addr >= `DCG_FLASH_LO_ADDR)
		else $error("protected write outside flash control");

	// flash control under protection takes only mass erase
	a_erase_only: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_ok && $past(limited) && wr_ok_addr == `DCG_FLASH_CTL_ADDR)
		|-> wr_ok_data == `DCG_MASS_ERASE)
		else $error("protected flash control write not mass erase");

	// program read refused under protection
	a_rpm_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_IDLE && cmd_valid && prot_s2 && cmd_byte == `DCG_CMD_RPM) |=> refuse)
		else $error("program read under protection");

	// register read refused under protection
	a_rreg_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(take && prot_s2 && cmd_byte == `DCG_CMD_RREG) |=> refuse)
		else $error("register read under protection");

	// program write refused under protection
	a_wpm_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(take && prot_s2 && cmd_byte == `DCG_CMD_WPM) |=> refuse)
		else $error("program write under protection");

	// data read runs in debug whatever the protection
	a_rdm_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(take && ctl_reg[`DCG_CTL_MODE_BIT] && cmd_byte == `DCG_CMD_RDM) |=> grant)
		else $error("data read refused in debug");

	// data write refused under protection
	a_wdm_prot: assert property (@(posedge clk) disable iff (!rst_n)
		(take && prot_s2 && cmd_byte == `DCG_CMD_WDM) |=> refuse)
		else $error("data write under protection");

	// checksum runs in debug whatever the protection
	a_crc_debug: assert property (@(posedge clk) disable iff (!rst_n)
		(take && ctl_reg[`DCG_CTL_MODE_BIT] && cmd_byte == `DCG_CMD_CRC) |=> grant)
		else $error("checksum refused in debug");

	// upper reserved code leaves everything as it was
	a_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		(state == DCG_IDLE && cmd_valid && cmd_byte == `DCG_CMD_RSVF)
		|=> refuse && $stable(ctl_reg) && state == DCG_IDLE)
		else $error("reserved code changed state");

	// lower reserved code leaves everything as it was
	a_reserved_lo: assert property (@(posedge clk) disable iff (!rst_n)
		(take && cmd_byte == `DCG_CMD_RSV1)
		|=> refuse && $stable(ctl_reg) && state == DCG_IDLE)
		else $error("lower reserved code changed state");

	// undefined codes above the step command are ignored
	a_undef_code: assert property (@(posedge clk) disable iff (!rst_n)
		(take && cmd_byte > `DCG_CMD_STEP)
		|=> refuse && $stable(ctl_reg) && state == DCG_IDLE)
		else $error("undefined code changed state");

	// ****************************************
	// cover points
	// ****************************************
	// a command accepted
	c_grant: cover property (@(posedge clk) disable iff (!rst_n) grant);
	// a command ignored
	c_refuse: cover property (@(posedge clk) disable iff (!rst_n) refuse);
	// a restricted register write let through
	c_limited_wr: cover property (@(posedge clk) disable iff (!rst_n) wr_ok && limited);
	// protected control write that tries to clear the debug bit
	c_mode_held: cover property (@(posedge clk) disable iff (!rst_n)
		state == DCG_EXEC && limited && wr_valid && active_cmd == `DCG_CMD_WCTL
		&& ctl_reg[`DCG_CTL_MODE_BIT] && !wr_data[`DCG_CTL_MODE_BIT]);
	// mass erase accepted under protection
	c_erase_ok: cover property (@(posedge clk) disable iff (!rst_n)
		wr_ok && limited && wr_ok_addr == `DCG_FLASH_CTL_ADDR);
endmodule // dcg_gate

/* File: tb/dcg_host.sv */
// debug host model: command bytes and data phases toward the gate
`timescale 1ns/10ps
module dcg_host (
	// clock
	input wire logic clk,
	// command and data phase toward the gate
	output logic cmd_valid = 1'b0,
	output logic [7:0] cmd_byte = 8'h5a,
	output logic wr_valid = 1'b0,
	output logic [11:0] wr_addr = 12'h5a5,
	output logic [7:0] wr_data = 8'ha5,
	output logic cmd_done = 1'b0
);
	// ****
	// host tasks
	// ****
	// every exchange opens with one command byte
	task automatic issue(input logic [7:0] c);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_byte <= c;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_byte <= ~c; // released byte shows no stale value
	endtask
	// one write word of the data phase
	task automatic put(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_valid <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_valid <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask
	// end of the data phase
	task automatic finish();
		@(posedge clk);
		cmd_done <= 1'b1;
		@(posedge clk);
		cmd_done <= 1'b0;
	endtask
endmodule // dcg_host

/* File: tb/debug_command_gate_bench.sv */
// self-checking bench of the debug command gate
`timescale 1ns/10ps
`include "dcg_map.svh"
`define DCG_CHK(g, e, m) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t %s", $time, m); end end
module debug_command_gate_bench;
	// ****
	// signals
	// ****
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic protect_pin = 1'b0;
	logic cmd_valid, wr_valid, cmd_done, grant, refuse, limited, wr_ok, debug_mode_flag;
	logic [7:0] cmd_byte, wr_data, active_cmd, wr_ok_data, ctl_reg;
	logic [11:0] wr_addr, wr_ok_addr;
	logic [7:0] r = 8'h2d; // random state, starts at 45
	logic [7:0] ectl, eact; // expected control reg and last code
	int fails = 0;
	int checks = 0;
	// clock of 100 ns
	initial begin
		forever #50 clk = ~clk;
	end
	// ****
	// instances
	// ****
	dcg_host i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .cmd_done(cmd_done));
	dcg_gate i_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .cmd_done(cmd_done),
		.protect_pin(protect_pin), .grant(grant), .refuse(refuse), .active_cmd(active_cmd),
		.limited(limited), .wr_ok(wr_ok), .wr_ok_addr(wr_ok_addr), .wr_ok_data(wr_ok_data),
		.ctl_reg(ctl_reg), .debug_mode_flag(debug_mode_flag));
	// ****
	// expectation functions
	// ****
	// next random value
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// expected verdict: 0 refused, 1 runs, 2 restricted
	function automatic int verdict(input logic [7:0] c, input logic dbg, input logic prot);
		if (c == `DCG_CMD_REV || c == `DCG_CMD_STAT || c == `DCG_CMD_RCTL) return 1;
		if (c == `DCG_CMD_WCTL) return prot ? 2 : 1;
		if (!dbg || c > 8'h10 || c == 8'h01 || c == 8'h0f) return 0;
		if (c == `DCG_CMD_WREG) return prot ? 2 : 1;
		if (prot && c inside {8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h10}) return 0;
		return 1;
	endfunction
	// ****
	// tasks
	// ****
	// closing report
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// reset held 20 cycles, then protect sync settles
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		ectl = `DCG_CTL_RESET;
		eact = 8'h00;
		repeat (3) @(posedge clk);
	endtask
	// one command with its data phase, checked end to end
	task automatic run(input logic [7:0] c, input logic [11:0] a, input logic [7:0] d);
		int v;
		logic ok;
		v = verdict(c, ectl[7], protect_pin);
		i_host.issue(c);
		#1;
		`DCG_CHK(grant, v != 0, "grant")
		`DCG_CHK(refuse, v == 0, "refuse")
		if (v != 0) begin
			eact = c;
			`DCG_CHK(limited, v == 2, "limited")
			if (c == `DCG_CMD_WCTL || c == `DCG_CMD_WREG) begin
				i_host.put(a, d);
				#1;
				if (c == `DCG_CMD_WREG) begin
					ok = !protect_pin || (a >= `DCG_FLASH_LO_ADDR && a <= `DCG_FLASH_HI_ADDR
						&& (a != `DCG_FLASH_CTL_ADDR || d == `DCG_MASS_ERASE));
					`DCG_CHK(wr_ok, ok, "write pass")
					if (ok) `DCG_CHK({wr_ok_addr, wr_ok_data}, {a, d}, "write word")
				end else begin
					`DCG_CHK(wr_ok, 1'b0, "no register write")
					ectl = (protect_pin && ectl[7]) ? (d | 8'h80) : d;
				end
			end
			i_host.finish();
		end
		repeat (3) @(posedge clk);
		#1;
		`DCG_CHK({debug_mode_flag, ctl_reg}, {ectl[7], ectl}, "control reg")
		`DCG_CHK(active_cmd, eact, "last code")
	endtask
	// codes 00 to 11, random codes and flash write corners in the present mode
	task automatic sweep(input int n);
		for (int c = 0; c < 8'h12; c++) begin
			r = lfsr(r);
			run(8'(c), {r[3:0], r}, (c == 4) ? {ectl[7], r[6:0]} : r);
		end
		for (int k = 0; k < 6; k++) begin
			r = lfsr(r);
			run(r | 8'h20, 12'h000, r);
		end
		run(`DCG_CMD_WREG, 12'hff8, 8'h63);
		run(`DCG_CMD_WREG, 12'hff8, 8'h62);
		run(`DCG_CMD_WREG, 12'hffb, r);
		run(`DCG_CMD_WREG, 12'hff7, r);
		$display("test %0d done", n);
	endtask
	// ****
	// main sequence and watchdog
	// ****
	initial begin
		repeat (60000) @(posedge clk);
		$display("MISMATCH t=%0t watchdog expired", $time);
		fails++;
		give_verdict();
	end
	initial begin
		do_reset();
		sweep(0);
		run(`DCG_CMD_WCTL, 12'h000, 8'h80);
		sweep(1);
		@(posedge clk);
		protect_pin <= 1'b1;
		repeat (3) @(posedge clk);
		sweep(2);
		run(`DCG_CMD_WCTL, 12'h000, 8'h00);
		do_reset();
		sweep(3);
		run(`DCG_CMD_WCTL, 12'h000, 8'h80);
		run(`DCG_CMD_WCTL, 12'h000, 8'h01);
		give_verdict();
	end
endmodule // debug_command_gate_bench
